// *** verilog/chc_pkg.sv ***
package chc_pkg;

    // Control word layout.
    localparam int          CHC_W_ADDR_LSB = 13;
    localparam int          CHC_W_RD       = 12;
    localparam int          CHC_W_BC       = 11;
    localparam int          CHC_W_ONES_LSB = 8;
    localparam logic [2:0]  CHC_W_ONES     = 3'h7;

    // Register addresses carried in the control word.
    localparam logic [2:0]  CHC_REG_CTRL2  = 3'h2;
    localparam logic [2:0]  CHC_REG_CTRL3  = 3'h3;

    // Fields of clock_filter_host_port_control.
    localparam int          CHC_R2_TURBO   = 7;
    localparam int          CHC_R2_BYPASS  = 6;
    localparam int          CHC_R2_HA_LSB  = 3;
    localparam int          CHC_R2_GEN_OUT = 2;
    localparam int          CHC_R2_HPS_LSB = 0;
    localparam logic [7:0]  CHC_R2_RESET   = 8'h20;

    // Fields of power_reset_rate_control.
    localparam int          CHC_R3_PD_LSB  = 4;
    localparam int          CHC_R3_SRST    = 3;
    localparam int          CHC_R3_RRF_LSB = 0;
    localparam logic [7:0]  CHC_R3_RESET   = 8'h01;

    // Sub-register index of register 3; the first one is the only one held here.
    localparam logic [1:0]  CHC_SUB_FIRST  = 2'h0;
    localparam logic [1:0]  CHC_SUB_LAST   = 2'h3;

    // Length of the internal reset triggered by software, in clock cycles.
    localparam logic [2:0]  CHC_SOFT_RST_CYCLES = 3'h4;

    // Turbo mode toggles the bit clock twice per prescale period.
    localparam logic [6:0]  CHC_TURBO_INC  = 7'h02;

    typedef enum logic [1:0] {
        CHC_HPS_I2C  = 2'h0,
        CHC_HPS_ALT  = 2'h1,
        CHC_HPS_GOUT = 2'h2,
        CHC_HPS_PASS = 2'h3
    } chc_hps_t;

    typedef enum logic [1:0] {
        CHC_PD_NONE = 2'h0,
        CHC_PD_ADC  = 2'h1,
        CHC_PD_DAC  = 2'h2,
        CHC_PD_ALL  = 2'h3
    } chc_pd_t;

    typedef enum logic [1:0] {
        CHC_ST_RUN  = 2'b01,
        CHC_ST_SRST = 2'b10
    } chc_state_t;

endpackage

// *** verilog/chc_div.sv ***
// Fractional clock divider: the output toggles inc_in times every mod_in input cycles.
module chc_div
    import chc_pkg::*;
#(
    parameter int W  = 17,
    parameter int IW = 7
) (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    // Rate
    input  wire logic [IW-1:0] inc_in,
    input  wire logic [W-1:0]  mod_in,
    // Divided clock
    output logic               clk_out
);

    logic [W:0] acc;
    logic [W:0] sum;
    logic       wrap;
    logic [W:0] next_acc;

    // An accumulator keeps the average rate exact when mod_in is not a multiple of inc_in.
    assign sum      = acc + {{(W + 1 - IW){1'b0}}, inc_in};
    assign wrap     = (mod_in != '0) && (sum >= {1'b0, mod_in});
    assign next_acc = wrap ? sum - {1'b0, mod_in} : sum;

    always_ff @(posedge clk_in) begin
        if (rst_in || mod_in == '0) begin
            acc     <= '0;
            clk_out <= 1'b0;
        end else begin
            acc     <= next_acc;
            clk_out <= clk_out ^ wrap;
        end
    end

endmodule // chc_div

// *** verilog/chc_regs.sv ***
module chc_regs
    import chc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Control words from the host port engine
    input  wire logic [15:0] word_in,
    input  wire logic        word_valid_in,
    input  wire logic        channel_in,
    output logic [7:0]       rd_data_out,
    output logic             rd_valid_out,
    // Host port engine pin requests
    input  wire logic        host_sda_in,
    input  wire logic        host_sda_oe_in,
    // Host port pins
    input  wire logic        scl_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    // Serial port
    input  wire logic        serial_dout_in,
    input  wire logic        frame_flag_in,
    input  wire logic        frame_tick_in,
    output logic             dout_out,
    output logic             sclk_out,
    output logic [1:0]       sample_tick_out,
    // Divider and cascade settings
    input  wire logic [6:0]  div_m_in,
    input  wire logic [3:0]  div_n_in,
    input  wire logic [2:0]  div_p_in,
    input  wire logic [3:0]  devices_in,
    input  wire logic [1:0]  mode_in,
    input  wire logic [3:0]  dev_addr_in,
    input  wire logic        diff_rate_in,
    // Configuration towards the codec
    output logic             turbo_out,
    output logic             filter_bypass_out,
    output logic [6:0]       host_address_out,
    output logic [1:0]       host_port_select_out,
    output logic [3:0]       power_down_out,
    output logic             soft_reset_out
);

    logic [7:0]  r2 [2];
    logic [7:0]  r3a [2];
    logic [1:0]  sub_idx [2];
    logic [2:0]  ratio_cnt [2];
    logic [2:0]  rst_cnt;
    chc_state_t  state;
    chc_state_t  next_state;
    logic [1:0]  scl_sync;

    // Decode of the control word.
    logic [2:0]  w_addr;
    logic        w_rd;
    logic        w_bc;
    logic        w_ok;
    logic        wr2;
    logic [1:0]  hit3;
    logic [1:0]  wr3a;
    logic        soft_go;
    logic        clr;
    chc_hps_t    hps;
    logic [7:0]  r3_view;
    logic [7:0]  next_rd_data;
    logic        next_sda;
    logic        next_sda_oe;
    logic        next_dout;
    logic [1:0]  next_tick;

    assign w_addr  = word_in[CHC_W_ADDR_LSB +: 3];
    assign w_rd    = word_in[CHC_W_RD];
    assign w_bc    = word_in[CHC_W_BC];
    // Words without the ones pattern, and all words during a soft reset, are ignored.
    assign w_ok    = word_valid_in && word_in[CHC_W_ONES_LSB +: 3] == CHC_W_ONES
                     && state == CHC_ST_RUN;
    assign wr2     = w_ok && !w_rd && w_addr == CHC_REG_CTRL2;
    assign soft_go = (wr3a != 2'b00) && word_in[CHC_R3_SRST];
    assign clr     = rst_in || state == CHC_ST_SRST;
    assign hps     = chc_hps_t'(r2[0][CHC_R2_HPS_LSB +: 2]);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            // A broadcast write reaches both channels; reads stay on the named one.
            assign hit3[g] = w_ok && w_addr == CHC_REG_CTRL3
                             && (channel_in == 1'(g) || (w_bc && !w_rd));
            assign wr3a[g] = hit3[g] && !w_rd && sub_idx[g] == CHC_SUB_FIRST;
            // A ratio code of 000 wraps to a last count of 7, giving a ratio of eight.
            assign next_tick[g] = frame_tick_in && (!diff_rate_in
                                  || ratio_cnt[g] == r3a[g][CHC_R3_RRF_LSB +: 3] - 3'h1);
        end
    endgenerate

    // The soft reset bit is shared, so it is shown from the state rather than stored twice.
    assign r3_view = (sub_idx[channel_in] == CHC_SUB_FIRST)
                     ? {2'b00, r3a[channel_in][5:4], state == CHC_ST_SRST,
                        r3a[channel_in][2:0]}
                     : {sub_idx[channel_in], 6'h00};
    assign next_rd_data = (w_addr == CHC_REG_CTRL2) ? r2[channel_in]
                        : (w_addr == CHC_REG_CTRL3) ? r3_view : 8'h00;

    always_comb begin
        next_sda    = host_sda_in;
        next_sda_oe = host_sda_oe_in;
        next_dout   = serial_dout_in;
        case (hps)
            CHC_HPS_I2C, CHC_HPS_ALT: begin
                next_sda    = host_sda_in;
                next_sda_oe = host_sda_oe_in;
            end
            CHC_HPS_GOUT: begin
                next_sda    = r2[0][CHC_R2_GEN_OUT];
                next_sda_oe = 1'b1;
            end
            CHC_HPS_PASS: begin
                next_sda    = frame_flag_in;
                next_sda_oe = 1'b1;
                next_dout   = scl_sync[1];
            end
            default: begin
                next_sda    = host_sda_in;
                next_sda_oe = host_sda_oe_in;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            CHC_ST_RUN:  if (soft_go) next_state = CHC_ST_SRST;
            CHC_ST_SRST: if (rst_cnt == 3'h1) next_state = CHC_ST_RUN;
            default:     next_state = CHC_ST_RUN;
        endcase
    end

    // Bit clock divider settings; codes of zero stand for the largest M, N and P.
    logic [7:0]  m_val;
    logic [4:0]  n_val;
    logic [3:0]  p_val;
    logic [16:0] mnp;
    logic [6:0]  slow_inc;
    logic [6:0]  div_inc;
    logic [16:0] div_mod;

    assign m_val    = (div_m_in == 7'h00) ? 8'h80 : {1'b0, div_m_in};
    assign n_val    = (div_n_in == 4'h0) ? 5'h10 : {1'b0, div_n_in};
    assign p_val    = (div_p_in == 3'h0) ? 4'h8 : {1'b0, div_p_in};
    assign mnp      = {9'h000, m_val} * {12'h000, n_val} * {13'h0000, p_val};
    // Bit clock over master clock is devices x mode / (M x N x P), so the 2s cancel.
    assign slow_inc = {2'b00, devices_in, 1'b0} * {5'h00, mode_in};
    assign div_inc  = r2[0][CHC_R2_TURBO] ? CHC_TURBO_INC : slow_inc;
    assign div_mod  = r2[0][CHC_R2_TURBO] ? {13'h0000, p_val} : mnp;

    chc_div #(.W(17), .IW(7)) u_div (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .inc_in  (div_inc),
        .mod_in  (div_mod),
        .clk_out (sclk_out)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state   <= CHC_ST_RUN;
            rst_cnt <= 3'h0;
        end else begin
            state   <= next_state;
            rst_cnt <= soft_go ? CHC_SOFT_RST_CYCLES : rst_cnt - {2'b00, rst_cnt != 3'h0};
        end
    end

    always_ff @(posedge clk_in) begin
        for (int c = 0; c < 2; c++) begin
            if (clr) begin
                r2[c]        <= CHC_R2_RESET;
                r3a[c]       <= CHC_R3_RESET;
                sub_idx[c]   <= CHC_SUB_FIRST;
                ratio_cnt[c] <= 3'h0;
            end else begin
                // Both copies of register 2 take every write, whichever channel it names.
                if (wr2) r2[c] <= word_in[7:0];
                if (wr3a[c]) r3a[c] <= {2'b00, word_in[5:4], 1'b0, word_in[2:0]};
                if (hit3[c]) sub_idx[c] <= sub_idx[c] + 2'h1;
                if (frame_tick_in) ratio_cnt[c] <= next_tick[c] ? 3'h0 : ratio_cnt[c] + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_sync <= 2'b00;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data_out          <= 8'h00;
            rd_valid_out         <= 1'b0;
            sda_out              <= 1'b0;
            sda_oe_out           <= 1'b0;
            dout_out             <= 1'b0;
            sample_tick_out      <= 2'b00;
            turbo_out            <= 1'b0;
            filter_bypass_out    <= 1'b0;
            host_address_out     <= {CHC_R2_RESET[CHC_R2_HA_LSB +: 3], 4'h0};
            host_port_select_out <= CHC_HPS_I2C;
            power_down_out       <= 4'h0;
            soft_reset_out       <= 1'b0;
        end else begin
            rd_data_out          <= next_rd_data;
            rd_valid_out         <= w_ok && w_rd;
            sda_out              <= next_sda;
            sda_oe_out           <= next_sda_oe;
            dout_out             <= next_dout;
            sample_tick_out      <= next_tick;
            turbo_out            <= r2[0][CHC_R2_TURBO];
            filter_bypass_out    <= r2[0][CHC_R2_BYPASS];
            host_address_out     <= {r2[0][CHC_R2_HA_LSB +: 3], dev_addr_in};
            host_port_select_out <= r2[0][CHC_R2_HPS_LSB +: 2];
            power_down_out       <= {r3a[1][CHC_R3_PD_LSB +: 2],
                                     r3a[0][CHC_R3_PD_LSB +: 2]};
            soft_reset_out       <= next_state == CHC_ST_SRST;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    slow_rate_a: assert property (!r2[0][CHC_R2_TURBO] |->
        div_inc == 7'(2 * devices_in * mode_in) && div_mod == mnp)
        else $error("Bit clock rate wrong with turbo clear.");

    turbo_rate_a: assert property (r2[0][CHC_R2_TURBO] |->
        div_inc == 7'h02 && div_mod == {13'h0000, p_val})
        else $error("Bit clock not master clock over P in turbo.");

    bypass_out_a: assert property (wr2 |=> ##1
        filter_bypass_out == $past(word_in[CHC_R2_BYPASS], 2))
        else $error("Filter bypass output does not follow the write.");

    addr_reset_a: assert property ($fell(rst_in) |->
        host_address_out[6:4] == 3'h4 && host_port_select_out == 2'h0)
        else $error("Host address or port select wrong after reset.");

    i2c_pins_a: assert property ($past(hps) inside {CHC_HPS_I2C, CHC_HPS_ALT} |->
        sda_oe_out == $past(host_sda_oe_in) && sda_out == $past(host_sda_in))
        else $error("Data pin not handed to the host port engine.");

    gen_out_drive_a: assert property ($past(hps) == CHC_HPS_GOUT |->
        sda_oe_out && sda_out == $past(r2[0][CHC_R2_GEN_OUT]))
        else $error("Data pin does not show the general output bit.");

    scl_pass_a: assert property ($past(hps, 1) == CHC_HPS_PASS
        && $past(hps, 3) == CHC_HPS_PASS
        |-> dout_out == $past(scl_in, 3) && sda_out == $past(frame_flag_in))
        else $error("Clock pin not passed to data out.");

    pd_clear_a: assert property ($fell(soft_reset_out) |=> power_down_out == 4'h0)
        else $error("Power down not cleared by soft reset.");

    soft_pulse_a: assert property (soft_go |=>
        soft_reset_out [*4] ##1 !soft_reset_out)
        else $error("Soft reset length wrong or bit stuck.");

    tick_rate_a: assert property (frame_tick_in && !diff_rate_in |=>
        sample_tick_out == 2'b11)
        else $error("Sample tick missing at frame rate.");

    shadow_a: assert property (r2[0] == r2[1])
        else $error("Shadowed register copies differ.");

    read_word_a: assert property (w_ok && w_rd && w_addr == CHC_REG_CTRL2 |=>
        rd_valid_out && rd_data_out == $past(r2[channel_in]))
        else $error("Read of register 2 returned wrong data.");

    sub_wrap_a: assert property (hit3[0] && sub_idx[0] == CHC_SUB_LAST |=>
        sub_idx[0] == CHC_SUB_FIRST)
        else $error("Sub-register index did not wrap.");

    soft_cover: cover property (soft_go ##1 soft_reset_out [*4]);
    pass_cover: cover property (hps == CHC_HPS_PASS ##3 dout_out);
    turbo_cover: cover property (r2[0][CHC_R2_TURBO] ##1 $rose(sclk_out));
    wrap_cover: cover property (hit3[0] && sub_idx[0] == CHC_SUB_LAST);

endmodule // chc_regs

// *** verif/chc_host_model.sv ***
module chc_host_model (
    // Clock and read answer
    input  wire logic       clk_in,
    input  wire logic       rd_valid_in,
    input  wire logic [7:0] rd_data_in,
    // Control words towards the device
    output logic [15:0]     word_out,
    output logic            word_valid_out,
    output logic            channel_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        word_out       = 16'h0000;
        word_valid_out = 1'b0;
        channel_out    = 1'b0;
    end

    // One word per call; any answer is taken at the falling edge after the taking edge.
    task automatic send(input logic [2:0] a, input logic rw, input logic bc, input logic ch,
                        input logic [7:0] d, input logic [2:0] ones,
                        output logic v, output logic [7:0] q);
        @(negedge clk_in);
        word_out       = {a, rw, bc, ones, d};
        word_valid_out = 1'b1;
        channel_out    = ch;
        @(negedge clk_in);
        v              = rd_valid_in;
        q              = rd_data_in;
        // The idle word is inverted so a stale value never looks like a fresh one.
        word_valid_out = 1'b0;
        word_out       = ~word_out;
        channel_out    = ~ch;
    endtask
endmodule // chc_host_model

// *** verif/test_codec_host_control_regs.sv ***
module test_codec_host_control_regs
    import chc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic host_sda_in = 1'b0, host_sda_oe_in = 1'b0, scl_in = 1'b0, serial_dout_in = 1'b0;
    logic frame_flag_in = 1'b0, frame_tick_in = 1'b0, diff_rate_in = 1'b0;
    logic [6:0] div_m_in = 7'h04;
    logic [3:0] div_n_in = 4'h2, devices_in = 4'h3, dev_addr_in = 4'h5;
    logic [2:0] div_p_in = 3'h3;
    logic [1:0] mode_in = 2'h2;
    logic [15:0] word_in;
    logic word_valid_in, channel_in, rd_valid_out, sda_out, sda_oe_out, dout_out, sclk_out;
    logic turbo_out, filter_bypass_out, soft_reset_out;
    logic [7:0] rd_data_out, reg2;
    logic [1:0] sample_tick_out, host_port_select_out;
    logic [6:0] host_address_out;
    logic [3:0] power_down_out;
    logic [7:0] r3a [2];
    int idx [2];
    int n_errors = 0;
    int checks = 0;

    always #5 clk_in = ~clk_in;

    chc_host_model host (.clk_in(clk_in), .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out),
        .word_out(word_in), .word_valid_out(word_valid_in), .channel_out(channel_in));

    chc_regs uut (.clk_in(clk_in), .rst_in(rst_in), .word_in(word_in),
        .word_valid_in(word_valid_in), .channel_in(channel_in), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .host_sda_in(host_sda_in), .host_sda_oe_in(host_sda_oe_in),
        .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .serial_dout_in(serial_dout_in), .frame_flag_in(frame_flag_in),
        .frame_tick_in(frame_tick_in), .dout_out(dout_out), .sclk_out(sclk_out),
        .sample_tick_out(sample_tick_out), .div_m_in(div_m_in), .div_n_in(div_n_in),
        .div_p_in(div_p_in), .devices_in(devices_in), .mode_in(mode_in),
        .dev_addr_in(dev_addr_in), .diff_rate_in(diff_rate_in), .turbo_out(turbo_out),
        .filter_bypass_out(filter_bypass_out), .host_address_out(host_address_out),
        .host_port_select_out(host_port_select_out), .power_down_out(power_down_out),
        .soft_reset_out(soft_reset_out));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic ch, input logic bc, input logic [7:0] d);
        logic       v;
        logic [7:0] q;
        host.send(a, 1'b0, bc, ch, d, 3'h7, v, q);
        chk({15'h0, v}, 16'h0000);
        if (a == CHC_REG_CTRL2) reg2 = d;
        if (a == CHC_REG_CTRL3) begin
            for (int c = 0; c < 2; c++) begin
                if (c == ch || bc) begin
                    if (idx[c] == 0) r3a[c] = d & 8'h37;
                    idx[c] = (idx[c] + 1) % 4;
                end
            end
        end
    endtask

    task automatic rd(input logic [2:0] a, input logic ch);
        logic       v;
        logic [7:0] q, e;
        e = 8'h00;
        if (a == CHC_REG_CTRL2) e = reg2;
        if (a == CHC_REG_CTRL3) begin
            e = (idx[ch] == 0) ? r3a[ch] : 8'(idx[ch] << 6);
            idx[ch] = (idx[ch] + 1) % 4;
        end
        host.send(a, 1'b1, 1'b0, ch, 8'h00, 3'h7, v, q);
        chk({7'h0, v, q}, {8'h01, e});
    endtask

    // A sub-register walk brings the index back to the stored sub-register.
    task automatic wr3(input logic ch, input logic [7:0] d);
        wr(CHC_REG_CTRL3, ch, 1'b0, d);
        repeat (3) rd(CHC_REG_CTRL3, ch);
    endtask

    task automatic chk_cfg;
        @(negedge clk_in);
        chk({1'b0, turbo_out, filter_bypass_out, host_address_out, host_port_select_out,
             power_down_out},
            {1'b0, reg2[7:3], dev_addr_in, reg2[1:0], r3a[1][5:4], r3a[0][5:4]});
    endtask

    task automatic tick(output logic [1:0] s);
        @(negedge clk_in);
        frame_tick_in = 1'b1;
        @(negedge clk_in);
        s             = sample_tick_out;
        frame_tick_in = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 10);
        n_errors++;
        final_report;
    end

    initial begin
        logic [7:0] d, q;
        logic [1:0] s;
        logic       v;
        int         t0, t1, n, cnt, e, prev;
        void'($urandom(25937));
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        reg2   = CHC_R2_RESET;
        r3a    = '{8'h01, 8'h01};
        idx    = '{0, 0};
        chk_cfg;
        for (int ch = 0; ch < 2; ch++) begin
            rd(CHC_REG_CTRL2, 1'(ch));
            rd(CHC_REG_CTRL3, 1'(ch));
            repeat (3) rd(CHC_REG_CTRL3, 1'(ch));
        end
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(CHC_REG_CTRL2, i[0], i[1], d);
            chk_cfg;
            rd(CHC_REG_CTRL2, ~i[0]);
        end
        host.send(CHC_REG_CTRL2, 1'b0, 1'b0, 1'b0, ~reg2, 3'h6, v, q);
        rd(CHC_REG_CTRL2, 1'b0);
        rd(3'h5, 1'b1);
        for (int m = 0; m < 8; m++) begin
            d      = 8'($urandom);
            d[1:0] = m[1:0];
            wr(CHC_REG_CTRL2, 1'b0, 1'b0, d);
            {host_sda_in, host_sda_oe_in, scl_in, serial_dout_in, frame_flag_in} = 5'($urandom);
            repeat (4) @(negedge clk_in);
            q = m[1] ? {5'h0, (m[0] ? frame_flag_in : reg2[2]), 1'b1,
                        (m[0] ? scl_in : serial_dout_in)}
                     : {5'h0, host_sda_in, host_sda_oe_in, serial_dout_in};
            chk({13'h0, sda_out, sda_oe_out, dout_out}, {8'h0, q});
        end
        for (int c = 0; c < 8; c++) begin
            wr3(c[0], {2'b00, c[2:1], 1'b0, 3'(c)});
            chk_cfg;
        end
        wr(CHC_REG_CTRL3, 1'b0, 1'b1, 8'h21);
        repeat (3) rd(CHC_REG_CTRL3, 1'b0);
        repeat (3) rd(CHC_REG_CTRL3, 1'b1);
        chk_cfg;
        wr3(1'b1, 8'h00);
        diff_rate_in = 1'b0;
        tick(s);
        chk({14'h0, s}, 16'h0003);
        diff_rate_in = 1'b1;
        for (int c = 1; c < 9; c++) begin
            wr3(1'b0, 8'(c % 8));
            repeat (8) tick(s);
            n  = c;
            t0 = 0;
            t1 = 0;
            repeat (3 * n) begin
                tick(s);
                t0 += int'(s[0] === 1'b1);
                t1 += int'(s[1] === 1'b1);
            end
            chk(16'(t0), 16'h0003);
            if (c == 8) chk(16'(t1), 16'h0003);
        end
        for (int t = 0; t < 2; t++) begin
            wr(CHC_REG_CTRL2, 1'b0, 1'b0, {t[0], reg2[6:0]});
            if (t == 1) div_p_in = 3'h5;
            repeat (50) @(negedge clk_in);
            cnt  = 0;
            prev = 1;
            repeat (240) begin
                @(negedge clk_in);
                cnt += int'(sclk_out === 1'b1 && prev == 0);
                prev = int'(sclk_out === 1'b1);
            end
            // The window need not align with the divider phase, so one edge of slack is allowed.
            e = t ? 48 : 60;
            chk(16'((cnt >= e - 1 && cnt <= e + 1) ? e : cnt), 16'(e));
        end
        wr(CHC_REG_CTRL3, 1'b0, 1'b0, 8'h3d);
        n = int'(soft_reset_out === 1'b1);
        fork
            host.send(CHC_REG_CTRL2, 1'b0, 1'b0, 1'b0, 8'hff, 3'h7, v, q);
            repeat (9) begin
                @(negedge clk_in);
                n += int'(soft_reset_out === 1'b1);
            end
        join
        chk(16'(n), {13'h0, CHC_SOFT_RST_CYCLES});
        reg2 = CHC_R2_RESET;
        r3a  = '{8'h01, 8'h01};
        idx  = '{0, 0};
        chk_cfg;
        rd(CHC_REG_CTRL2, 1'b1);
        final_report;
    end
endmodule // test_codec_host_control_regs
